// File: core_regulator_control_regs.sv
// core_regulator_control_regs: control and status for the core regulator
// and its undervoltage detector, with reset-cause flags and an interrupt
// assumes: analogue comparators give level outputs synchronous to clock
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module core_regulator_control_regs
  import regctl_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              irq_page_i,
  input  wire logic              supply_fresh_i,
  input  wire logic              feeds_core_i,
  input  wire logic              above_assert_i,
  input  wire logic              below_deassert_i,
  input  wire logic              had_por_i,
  input  wire logic              had_run_i,
  input  wire logic              had_debug_i,
  output logic [31:0]            rdata_o,
  output logic                   reg_enable_o,
  output logic                   pin_release_o,
  output logic                   pin_pulldown_o,
  output logic [3:0]             output_level_code_o,
  output logic                   undervoltage_detect_o,
  output logic [3:0]             uv_level_code_o,
  output logic                   reset_event_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  bus_req_type req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction : hit

  function automatic reg_mode_type mode_of(input reg_ctrl_type c);
    if (!c.on) begin
      mode_of = MODE_SHUTDOWN;
    end else if (c.float_sel) begin
      mode_of = MODE_FLOAT;
    end else begin
      mode_of = MODE_NORMAL;
    end
  endfunction : mode_of

  // irq_page_i selects the interrupt enable/clear window at 0x0 and 0x4
  logic sel_ctrl, sel_uv, sel_cause, sel_stat, sel_ien, sel_iclr;
  assign sel_ctrl  = !irq_page_i && hit(req.addr, OFF_REG_CTRL);
  assign sel_uv    = !irq_page_i && hit(req.addr, OFF_UV_CTRL);
  assign sel_cause = !irq_page_i && hit(req.addr, OFF_RESET_CAUSE);
  assign sel_stat  = !irq_page_i && hit(req.addr, OFF_IRQ_STATUS);
  assign sel_ien   = irq_page_i && hit(req.addr, OFF_IRQ_ENABLE);
  assign sel_iclr  = irq_page_i && hit(req.addr, OFF_IRQ_CLEAR);

  ////////////////////////////////////////////////////////////////////////
  // control registers
  reg_ctrl_type ctrl_q, ctrl_d;
  uv_ctrl_type  uv_q, uv_d;
  logic         latched_off_q, latched_off_d;
  logic         level_raised;
  logic         shut_req;

  always_comb begin
    ctrl_d        = ctrl_q;
    uv_d          = uv_q;
    latched_off_d = latched_off_q;
    level_raised  = 1'b0;
    shut_req      = 1'b0;
    if (req.wr && sel_ctrl && !latched_off_q) begin
      // reserved bits are simply not stored
      ctrl_d.on        = req.wdata[POS_ON];
      ctrl_d.float_sel = req.wdata[POS_FLOAT];
      ctrl_d.level     = req.wdata[POS_CODE_LO +: 4];
      level_raised     = ctrl_d.level > ctrl_q.level;
      shut_req         = !req.wdata[POS_ON];
    end
    if (req.wr && sel_uv) begin
      uv_d.on    = req.wdata[POS_UV_ON];
      uv_d.level = req.wdata[POS_CODE_LO +: 4];
    end
    // clear first so that a shutdown in the same cycle still latches
    if (supply_fresh_i) begin
      latched_off_d = 1'b0;
    end
    if (shut_req && feeds_core_i && uv_d.on) begin
      // brown-out will fire; regulator comes back as after reset
      ctrl_d = '{on: RST_ON, float_sel: RST_FLOAT, level: RST_LEVEL};
    end else if (shut_req && !uv_d.on) begin
      latched_off_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= '{on: RST_ON, float_sel: RST_FLOAT, level: RST_LEVEL};
      uv_q   <= '{on: RST_UV_ON, level: RST_UV_LEVEL};
      latched_off_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      uv_q   <= uv_d;
      latched_off_q <= latched_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analogue controls
  reg_mode_type mode;
  logic         reset_pulse;
  assign mode = latched_off_q ? MODE_SHUTDOWN : mode_of(ctrl_q);
  assign reset_pulse = shut_req && feeds_core_i && uv_d.on;

  logic enable_d, release_d, pulldown_d;
  always_comb begin
    enable_d   = 1'b0;
    release_d  = 1'b0;
    pulldown_d = 1'b0;
    unique case (mode)
      MODE_NORMAL:   enable_d   = 1'b1;
      MODE_FLOAT:    release_d  = 1'b1;
      MODE_SHUTDOWN: pulldown_d = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_enable_o          <= 1'b1;
      pin_release_o         <= 1'b0;
      pin_pulldown_o        <= 1'b0;
      output_level_code_o   <= RST_LEVEL;
      undervoltage_detect_o <= RST_UV_ON;
      uv_level_code_o       <= RST_UV_LEVEL;
      reset_event_o         <= 1'b0;
    end else begin
      reg_enable_o          <= enable_d;
      pin_release_o         <= release_d;
      pin_pulldown_o        <= pulldown_d;
      output_level_code_o   <= ctrl_q.level;
      undervoltage_detect_o <= uv_q.on;
      uv_level_code_o       <= uv_q.level;
      reset_event_o         <= reset_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // regulation-good flag
  logic good;
  good_tracker u_good (
    .ref_clk_i        (ref_clk_i),
    .rst_b_i          (rst_b_i),
    .above_assert_i   (above_assert_i),
    .below_deassert_i (below_deassert_i),
    .level_raised_i   (level_raised),
    .float_mode_i     (mode == MODE_FLOAT),
    .enabled_i        (mode != MODE_SHUTDOWN),
    .good_o           (good)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupts: status is sticky, set wins over clear
  logic [IRQ_W-1:0] stat_q, stat_d, ien_q, ien_d, events;
  logic             good_prev_q;

  always_comb begin
    events = '0;
    events[IRQ_GOOD_RISE] = good && !good_prev_q;
    events[IRQ_GOOD_FALL] = !good && good_prev_q;
    events[IRQ_RESET_REQ] = reset_pulse;
    events[IRQ_LATCH_OFF] = latched_off_d && !latched_off_q;
    stat_d = stat_q;
    if (req.wr && sel_iclr) begin
      stat_d = stat_q & ~req.wdata[IRQ_W-1:0];
    end
    stat_d = stat_d | events;
    ien_d = ien_q;
    if (req.wr && sel_ien) begin
      ien_d = req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_q      <= '0;
      ien_q       <= '0;
      good_prev_q <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      stat_q      <= stat_d;
      ien_q       <= ien_d;
      good_prev_q <= good;
      irq_o       <= |(stat_d & ien_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: data stand one cycle after the strobe only
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      if (sel_ctrl) begin
        rdata_d[POS_ON]           = ctrl_q.on && !latched_off_q;
        rdata_d[POS_FLOAT]        = ctrl_q.float_sel;
        rdata_d[POS_CODE_LO +: 4] = ctrl_q.level;
        rdata_d[POS_GOOD]         = good;
      end else if (sel_uv) begin
        rdata_d[POS_UV_ON]        = uv_q.on;
        rdata_d[POS_CODE_LO +: 4] = uv_q.level;
      end else if (sel_cause) begin
        rdata_d[POS_HAD_POR]   = had_por_i;
        rdata_d[POS_HAD_RUN]   = had_run_i;
        rdata_d[POS_HAD_DEBUG] = had_debug_i;
      end else if (sel_stat) begin
        rdata_d[IRQ_W-1:0] = stat_q;
      end else if (sel_ien) begin
        rdata_d[IRQ_W-1:0] = ien_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_d;
    end
  end

endmodule : core_regulator_control_regs
`default_nettype wire

// File: good_tracker.sv
// good_tracker: regulation-good flag with hysteresis and level-raise drop
// assumes: comparator inputs are synchronous to ref_clk_i
`timescale 1ns/1ns
`default_nettype none
module good_tracker
  import regctl_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       above_assert_i,
  input  wire logic       below_deassert_i,
  input  wire logic       level_raised_i,
  input  wire logic       float_mode_i,
  input  wire logic       enabled_i,
  output logic            good_o
);

  logic good_d;

  always_comb begin
    good_d = good_o;
    if (above_assert_i) begin
      good_d = 1'b1;
    end
    if (below_deassert_i) begin
      good_d = 1'b0;
    end
    if (level_raised_i || float_mode_i || !enabled_i) begin
      good_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      good_o <= 1'b0;
    end else begin
      good_o <= good_d;
    end
  end

endmodule : good_tracker
`default_nettype wire

// File: regctl_chk.sv
// regctl_chk: port-level assertions for the regulator register bank
// assumes: bound into core_regulator_control_regs, single clock domain
`timescale 1ns/1ns
`default_nettype none
module regctl_chk
  import regctl_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0]       wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic              irq_page_i,
  input wire logic              supply_fresh_i,
  input wire logic              feeds_core_i,
  input wire logic [31:0]       rdata_o,
  input wire logic              reg_enable_o,
  input wire logic              pin_release_o,
  input wire logic              pin_pulldown_o,
  input wire logic [3:0]        output_level_code_o,
  input wire logic              undervoltage_detect_o,
  input wire logic [3:0]        uv_level_code_o,
  input wire logic              reset_event_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // remembers a shutdown taken while detection was off, until supply cycles
  logic latch_seen_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_seen_q <= 1'b0;
    end else if (wr_i && !irq_page_i && addr_i == OFF_REG_CTRL &&
                 !wdata_i[0] && !undervoltage_detect_o) begin
      latch_seen_q <= 1'b1;
    end else if (supply_fresh_i) begin
      latch_seen_q <= 1'b0;
    end
  end
  // shutdown state (pin_pulldown_o) is left out: covers latched-off, where ctrl writes are ignored
  sequence s_ctl_wr;
    wr_i && !irq_page_i && addr_i == OFF_REG_CTRL && !pin_pulldown_o;
  endsequence
  a_mode_onehot: assert property (
    $onehot({reg_enable_o, pin_release_o, pin_pulldown_o}))
    else $error("mode outputs not one-hot");
  a_normal_mode: assert property (
    s_ctl_wr ##0 wdata_i[1:0] == 2'b01 |-> ##2 reg_enable_o)
    else $error("normal mode not entered");
  a_float_mode: assert property (
    s_ctl_wr ##0 wdata_i[1:0] == 2'b11 |-> ##2 pin_release_o)
    else $error("float mode not entered");
  a_level_load: assert property (
    s_ctl_wr ##0 wdata_i[0] |->
    ##2 output_level_code_o == $past(wdata_i[7:4], 2))
    else $error("level code not loaded");
  a_event_pulse: assert property (
    s_ctl_wr ##0 (!wdata_i[0] && feeds_core_i && undervoltage_detect_o)
    |=> reset_event_o ##1 !reset_event_o)
    else $error("reset event missing or long");
  a_event_normal: assert property (
    reset_event_o |=> reg_enable_o && output_level_code_o == RST_LEVEL)
    else $error("no return to defaults");
  a_latch_hold: assert property (
    latch_seen_q && !supply_fresh_i |=> pin_pulldown_o)
    else $error("latched shutdown left");
  a_ctl_resv: assert property (
    $past(rd_i && !irq_page_i && addr_i == OFF_REG_CTRL) |->
    (rdata_o & 32'hffff_ef0c) == 32'h0000_0000)
    else $error("reserved ctrl bits set");
  a_uv_load: assert property (
    wr_i && !irq_page_i && addr_i == OFF_UV_CTRL |->
    ##2 {uv_level_code_o, undervoltage_detect_o} ==
    {$past(wdata_i[7:4], 2), $past(wdata_i[0], 2)})
    else $error("detector fields not loaded");
endmodule : regctl_chk
bind core_regulator_control_regs regctl_chk i_chk (.ref_clk_i, .rst_b_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .irq_page_i, .supply_fresh_i,
  .feeds_core_i, .rdata_o, .reg_enable_o, .pin_release_o, .pin_pulldown_o,
  .output_level_code_o, .undervoltage_detect_o, .uv_level_code_o,
  .reset_event_o);
`default_nettype wire

// File: regctl_pkg.sv
// package: register map, field layout, reset values and types for the
// core regulator control register bank
// assumes: 32-bit word registers on a plain strobe port
package regctl_pkg;

  localparam logic [31:0] BASE_ADDR        = 32'h4006_4000;
  localparam logic [3:0]  OFF_REG_CTRL     = 4'h0;
  localparam logic [3:0]  OFF_UV_CTRL      = 4'h4;
  localparam logic [3:0]  OFF_RESET_CAUSE  = 4'h8;
  localparam logic [3:0]  OFF_IRQ_STATUS   = 4'hc;
  localparam int          ADDR_W           = 4;

  // interrupt registers share one word layout
  localparam logic [3:0]  OFF_IRQ_ENABLE   = 4'h0;
  localparam logic [3:0]  OFF_IRQ_CLEAR    = 4'h4;

  localparam int          POS_ON           = 0;
  localparam int          POS_FLOAT        = 1;
  localparam int          POS_CODE_LO      = 4;
  localparam int          POS_GOOD         = 12;
  localparam int          POS_UV_ON        = 0;
  localparam int          POS_HAD_POR      = 8;
  localparam int          POS_HAD_RUN      = 16;
  localparam int          POS_HAD_DEBUG    = 20;

  localparam logic        RST_ON           = 1'b1;
  localparam logic        RST_FLOAT        = 1'b0;
  localparam logic [3:0]  RST_LEVEL        = 4'hb;
  localparam logic [3:0]  RST_UV_LEVEL     = 4'h9;
  localparam logic        RST_UV_ON        = 1'b1;

  // status bit positions of the interrupt word
  localparam int          IRQ_GOOD_RISE    = 0;
  localparam int          IRQ_GOOD_FALL    = 1;
  localparam int          IRQ_RESET_REQ    = 2;
  localparam int          IRQ_LATCH_OFF    = 3;
  localparam int          IRQ_W            = 4;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FLOAT,
    MODE_SHUTDOWN
  } reg_mode_type;

  typedef struct packed {
    logic       on;
    logic       float_sel;
    logic [3:0] level;
  } reg_ctrl_type;

  typedef struct packed {
    logic       on;
    logic [3:0] level;
  } uv_ctrl_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

endpackage : regctl_pkg

// File: tb.sv
// tb: self-checking bench for the regulator register bank
// assumes: package and design compiled first; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb;
  import regctl_pkg::*;
  logic ref_clk_i, rst_b_i, wr_i, rd_i, irq_page_i, supply_fresh_i;
  logic feeds_core_i, above_assert_i, below_deassert_i;
  logic had_por_i, had_run_i, had_debug_i, reg_enable_o, pin_release_o;
  logic pin_pulldown_o, undervoltage_detect_o, reset_event_o, irq_o;
  logic [3:0]  addr_i, output_level_code_o, uv_level_code_o, m_lvl, m_uvl;
  logic [31:0] wdata_i, rdata_o, r, seed;
  logic        m_on, m_flt, m_uv;
  int          miscompares, cmp_count, i;
  core_regulator_control_regs i_core_regulator_control_regs (.*);
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task put(input logic w, input logic [3:0] a, input logic [31:0] d,
           input logic pg);
    @(posedge ref_clk_i);
    wr_i <= w; rd_i <= !w; addr_i <= a; wdata_i <= d; irq_page_i <= pg;
  endtask : put
  task fin;
    @(posedge ref_clk_i);
    wr_i <= 1'b0; rd_i <= 1'b0;
  endtask : fin
  task wr(input logic [3:0] a, input logic [31:0] d, input logic pg);
    put(1'b1, a, d, pg); fin; @(posedge ref_clk_i); #1;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    put(1'b0, a, 32'h0000_0000, 1'b0); fin; #1;
    chk("rdata", e & m, rdata_o & m);
  endtask : rd
  task outs;
    chk("mode", {m_on & !m_flt, m_on & m_flt, !m_on},
        {reg_enable_o, pin_release_o, pin_pulldown_o});
    chk("levels", {m_lvl, m_uvl, m_uv},
        {output_level_code_o, uv_level_code_o, undervoltage_detect_o});
  endtask : outs
  task results;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    miscompares++;
    results;
  end
  initial begin
    seed = 32'h77e6; rst_b_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0;
    addr_i = 4'h0; wdata_i = '0; irq_page_i = 1'b0; supply_fresh_i = 1'b0;
    feeds_core_i = 1'b1; above_assert_i = 1'b0; below_deassert_i = 1'b1;
    {had_por_i, had_run_i, had_debug_i} = 3'($random(seed));
    {m_on, m_flt, m_lvl, m_uv, m_uvl} = {2'b10, RST_LEVEL, 1'b1, RST_UV_LEVEL};
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1 outs;
    rd(OFF_REG_CTRL, {24'h0, m_lvl, 4'h1}, '1);
    rd(OFF_UV_CTRL, {24'h0, m_uvl, 4'h1}, '1);
    rd(OFF_RESET_CAUSE, {11'h0, had_debug_i, 3'h0, had_run_i, 7'h0,
       had_por_i, 8'h0}, '1);
    wr(4'h2, '1, 1'b0);
    rd(4'h2, 32'h0000_0000, '1);
    for (i = 0; i < 8; i++) begin
      r = $random(seed) | 32'h1;
      {m_lvl, m_flt} = {r[7:4], r[1]};
      wr(OFF_REG_CTRL, r, 1'b0); outs;
      rd(OFF_REG_CTRL, {24'h0, m_lvl, 2'h0, m_flt, 1'b1}, '1);
      r = $random(seed) | 32'h1;
      m_uvl = r[7:4];
      wr(OFF_UV_CTRL, r, 1'b0); rd(OFF_UV_CTRL, {r[7:4], 4'h1}, '1);
    end
    feeds_core_i = 1'b0;
    {m_on, m_flt, m_lvl} = {2'b00, 4'hb};
    wr(OFF_REG_CTRL, 32'h0000_00b0, 1'b0); outs;
    m_on = 1'b1;
    wr(OFF_REG_CTRL, 32'h0000_00b1, 1'b0); outs;
    feeds_core_i = 1'b1; above_assert_i = 1'b1; below_deassert_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rd(OFF_REG_CTRL, 32'h0000_1000, 32'h0000_1000);
    // read rides right behind the raising write, before recovery
    put(1'b1, OFF_REG_CTRL, 32'h0000_00f1, 1'b0);
    rd(OFF_REG_CTRL, 32'h0000_0000, 32'h0000_1000);
    m_flt = 1'b1;
    wr(OFF_REG_CTRL, 32'h0000_00f3, 1'b0); repeat (3) @(posedge ref_clk_i);
    rd(OFF_REG_CTRL, 32'h0000_0000, 32'h0000_1000);
    above_assert_i = 1'b0; below_deassert_i = 1'b1;
    wr(OFF_IRQ_ENABLE, 32'h0000_0004, 1'b1);
    put(1'b1, OFF_REG_CTRL, 32'h0000_00f0, 1'b0); fin; #1;
    chk("event", 32'h1, {31'h0, reset_event_o});
    {m_on, m_flt, m_lvl} = {2'b10, 4'hb};
    repeat (2) @(posedge ref_clk_i); #1 outs;
    rd(OFF_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(OFF_IRQ_ENABLE, 32'h0000_0000, 1'b1);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(OFF_IRQ_ENABLE, 32'h0000_0004, 1'b1);
    wr(OFF_IRQ_CLEAR, 32'h0000_0004, 1'b1); @(posedge ref_clk_i); #1;
    chk("irq", 32'h0, {31'h0, irq_o});
    {feeds_core_i, m_uv, m_on} = 3'b000;
    wr(OFF_UV_CTRL, {24'h0, m_uvl, 4'h0}, 1'b0);
    wr(OFF_REG_CTRL, 32'h0000_00b0, 1'b0); outs;
    rd(OFF_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(OFF_REG_CTRL, 32'h0000_00b1, 1'b0); outs;
    rd(OFF_REG_CTRL, 32'h0000_00b0, 32'hffff_efff);
    supply_fresh_i = 1'b1; @(posedge ref_clk_i); #1 supply_fresh_i = 1'b0;
    {m_uv, m_on} = 2'b11;
    wr(OFF_UV_CTRL, {24'h0, m_uvl, 4'h1}, 1'b0);
    wr(OFF_REG_CTRL, 32'h0000_00b1, 1'b0); outs;
    // mid-run reset from a float, low-level state must restore defaults
    wr(OFF_REG_CTRL, 32'h0000_0053, 1'b0);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    {m_on, m_flt, m_lvl, m_uv, m_uvl} = {2'b10, RST_LEVEL, 1'b1, RST_UV_LEVEL};
    #1 outs;
    rd(OFF_REG_CTRL, 32'h0000_00b1, '1);
    rd(OFF_UV_CTRL, 32'h0000_0091, '1);
    results;
  end
endmodule : tb
`default_nettype wire
